// ==== dv/interrupt_source_summary_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module interrupt_source_summary_tb;
	logic                 clk_i = 1'b0;
	logic                 rst_i = 1'b1;
	logic [16:0]          ch_q = 17'h0;
	logic                 tick_q = 1'b0;
	iss_pkg::iss_wb_req_s req_q = '0;
	iss_pkg::iss_wb_rsp_s rsp;
	logic                 irq;
	logic [31:0]          rd;
	int                   miscompares = 0;
	int                   total_checks = 0;
	iss_summary u_dut (.clk_i(clk_i), .rst_i(rst_i), .channel_pending_flag_i(ch_q),
		.second_tick_i(tick_q), .wb_req_i(req_q), .wb_rsp_o(rsp), .irq_o(irq));
	initial forever #10 clk_i = ~clk_i;
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	// The answer time is not assumed; a bounded wait catches a dead slave
	task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		req_q <= '{adr: a, dat: wd, sel: 4'hf, we: we, cyc: 1'b1, stb: 1'b1};
		@(posedge clk_i);
		while (rsp.ack !== 1'b1 && n < 20)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n == 20)
			check(32'h1, 32'h0);
		rd = rsp.dat;
		req_q <= '0;
		@(posedge clk_i);
	endtask : bus
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(rd, e);
	endtask : rchk
	task automatic pulse;
		tick_q <= 1'b1;
		@(posedge clk_i);
		tick_q <= 1'b0;
		@(posedge clk_i);
	endtask : pulse
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rchk(iss_pkg::SUMMARY_LOW_ADDR, 32'h0);
		rchk(iss_pkg::SUMMARY_HIGH_ADDR, 32'h0);
		rchk(iss_pkg::SUMMARY_ZERO_ADDR, 32'h0);
		rchk(iss_pkg::TIMER_STATUS_ADDR, 32'h0);
		rchk(iss_pkg::IRQ_MASK_ADDR, 32'h0);
		$display("reset values done");
		for (int c = 0; c < 18; c++)
		begin
			ch_q <= (c < 17) ? (17'h1 << c) : 17'h1ffff;
			@(posedge clk_i);
			rchk(iss_pkg::SUMMARY_LOW_ADDR, {24'h0, ch_q[8:1]});
			rchk(iss_pkg::SUMMARY_HIGH_ADDR, {24'h0, ch_q[16:9]});
			rchk(iss_pkg::SUMMARY_ZERO_ADDR, {24'h0, ch_q[0], 7'h0});
		end
		bus(1'b1, iss_pkg::SUMMARY_LOW_ADDR, 32'hff);
		rchk(iss_pkg::SUMMARY_LOW_ADDR, 32'hff);
		ch_q <= 17'h0;
		@(posedge clk_i);
		rchk(iss_pkg::SUMMARY_LOW_ADDR, 32'h0);
		rchk(iss_pkg::SUMMARY_ZERO_ADDR, 32'h0);
		rchk(12'h100, 32'h0);
		$display("channel map done");
		pulse();
		rchk(iss_pkg::TIMER_STATUS_ADDR, 32'h1);
		bus(1'b1, iss_pkg::TIMER_STATUS_ADDR, 32'h0);
		rchk(iss_pkg::TIMER_STATUS_ADDR, 32'h1);
		bus(1'b1, iss_pkg::TIMER_STATUS_ADDR, 32'h1);
		rchk(iss_pkg::TIMER_STATUS_ADDR, 32'h0);
		// Expiry lands on the very edge that commits the clearing write
		fork
			bus(1'b1, iss_pkg::TIMER_STATUS_ADDR, 32'h1);
			begin
				@(posedge clk_i);
				pulse();
			end
		join
		rchk(iss_pkg::TIMER_STATUS_ADDR, 32'h1);
		bus(1'b1, iss_pkg::TIMER_STATUS_ADDR, 32'h1);
		rchk(iss_pkg::TIMER_STATUS_ADDR, 32'h0);
		$display("timer flag done");
		bus(1'b1, iss_pkg::IRQ_MASK_ADDR, 32'h3);
		check({31'h0, irq}, 32'h1);
		rchk(iss_pkg::IRQ_STATUS_ADDR, 32'h3);
		check({31'h0, irq}, 32'h0);
		bus(1'b1, iss_pkg::IRQ_MASK_ADDR, 32'h0);
		pulse();
		check({31'h0, irq}, 32'h0);
		rchk(iss_pkg::IRQ_STATUS_ADDR, 32'h2);
		$display("interrupt done");
		tally_and_finish();
	end
	initial
	begin
		repeat (3000) @(posedge clk_i);
		miscompares++;
		tally_and_finish();
	end
endmodule : interrupt_source_summary_tb
`default_nettype wire

// ==== rtl/iss_summary.sv ====
// Contract
// - Low summary register bits 7..0 reflect channels 8..1, bit n-1 for channel n.
// - High summary register bits 7..0 reflect channels 16..9.
// - Zero summary register bit 7 is channel 0; bits 6..0 reserved, read zero.
// - Summary bit reads one while channel has pending interrupt; zero otherwise and at reset.
// - Timer overflow flag bit 0 sets whenever the one-second timer expires.
// - Software writes one to clear the overflow flag; reset value zero.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module iss_summary #(
	parameter int unsigned NUM_CHANNELS = iss_pkg::NUM_CHANNELS
) (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic [NUM_CHANNELS-1:0]   channel_pending_flag_i,
	input  wire logic                      second_tick_i,
	input  wire iss_pkg::iss_wb_req_s      wb_req_i,
	output var iss_pkg::iss_wb_rsp_s       wb_rsp_o,
	output logic                           irq_o
);
	generate
		if (NUM_CHANNELS != iss_pkg::NUM_CHANNELS)
		begin : g_bad_channels
			$error("iss_summary serves exactly 17 channels");
		end
	endgenerate

	logic [NUM_CHANNELS-1:0] pending_q;
	logic                    second_overflow_flag_q;
	logic [1:0]              irq_status_q;
	logic [1:0]              irq_mask_q;
	logic                    ack_q;
	logic [31:0]             rdata_q;
	logic                    access;
	logic                    wr_en;
	logic                    rd_en;
	logic                    any_pending_q;
	logic [1:0]              events;
	logic [31:0]             rdata_d;
	logic                    overflow_clear;
	logic                    status_read;
	logic                    mask_write;

	// Channel flags come from per-channel logic on this same clock
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pending_q <= '0;
		else
			pending_q <= channel_pending_flag_i;
	end

	// Reads are taken at the request edge; writes commit on the edge that sees ack high
	assign access = wb_req_i.cyc && wb_req_i.stb && !ack_q;
	assign wr_en  = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && ack_q;
	assign rd_en  = access && !wb_req_i.we;

	function automatic logic reg_hit(
		input logic [iss_pkg::ADDR_W-1:0] adr,
		input logic [iss_pkg::ADDR_W-1:0] target
	);
		reg_hit = (adr == target);
	endfunction : reg_hit

	// Holes in the map read zero and swallow writes
	function automatic logic addr_mapped(input logic [iss_pkg::ADDR_W-1:0] adr);
		addr_mapped = reg_hit(adr, iss_pkg::SUMMARY_LOW_ADDR)
			|| reg_hit(adr, iss_pkg::SUMMARY_HIGH_ADDR)
			|| reg_hit(adr, iss_pkg::SUMMARY_ZERO_ADDR)
			|| reg_hit(adr, iss_pkg::TIMER_STATUS_ADDR)
			|| reg_hit(adr, iss_pkg::IRQ_STATUS_ADDR)
			|| reg_hit(adr, iss_pkg::IRQ_MASK_ADDR);
	endfunction : addr_mapped

	function automatic logic [iss_pkg::REG_W-1:0] summary_low(
		input logic [NUM_CHANNELS-1:0] p
	);
		summary_low = p[iss_pkg::LOW_CH_BASE +: iss_pkg::REG_W];
	endfunction : summary_low

	function automatic logic [iss_pkg::REG_W-1:0] summary_high(
		input logic [NUM_CHANNELS-1:0] p
	);
		summary_high = p[iss_pkg::HIGH_CH_BASE +: iss_pkg::REG_W];
	endfunction : summary_high

	function automatic logic [iss_pkg::REG_W-1:0] summary_zero(
		input logic [NUM_CHANNELS-1:0] p
	);
		summary_zero                      = '0;
		summary_zero[iss_pkg::ZERO_CH_BIT] = p[0];
	endfunction : summary_zero

	// Only the low byte lane carries these 8-bit registers
	assign overflow_clear = wr_en && wb_req_i.sel[0] && wb_req_i.dat[iss_pkg::OVERFLOW_BIT]
		&& reg_hit(wb_req_i.adr, iss_pkg::TIMER_STATUS_ADDR);
	assign status_read    = rd_en && reg_hit(wb_req_i.adr, iss_pkg::IRQ_STATUS_ADDR);
	assign mask_write     = wr_en && wb_req_i.sel[0]
		&& reg_hit(wb_req_i.adr, iss_pkg::IRQ_MASK_ADDR);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			second_overflow_flag_q <= 1'b0;
		else if (second_tick_i)
			second_overflow_flag_q <= 1'b1;
		else if (overflow_clear)
			second_overflow_flag_q <= 1'b0;
	end

	// Event sources: rising summary activity and a timer expiry
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			any_pending_q <= 1'b0;
		else
			any_pending_q <= |pending_q;
	end

	always_comb
	begin
		events = '0;
		events[iss_pkg::EV_CHANNEL_BIT]  = (|pending_q) && !any_pending_q;
		events[iss_pkg::EV_OVERFLOW_BIT] = second_tick_i;
	end

	// A read clears status, but a same-cycle event still wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_status_q <= '0;
		else if (status_read)
			irq_status_q <= events;
		else
			irq_status_q <= irq_status_q | events;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_mask_q <= '0;
		else if (mask_write)
			irq_mask_q <= wb_req_i.dat[1:0];
	end

	assign irq_o = |(irq_status_q & irq_mask_q);

	always_comb
	begin
		rdata_d = iss_pkg::UNMAPPED_DATA;
		case (wb_req_i.adr)
			iss_pkg::SUMMARY_LOW_ADDR:
				rdata_d[7:0] = summary_low(pending_q);
			iss_pkg::SUMMARY_HIGH_ADDR:
				rdata_d[7:0] = summary_high(pending_q);
			iss_pkg::SUMMARY_ZERO_ADDR:
				rdata_d[7:0] = summary_zero(pending_q);
			iss_pkg::TIMER_STATUS_ADDR:
				rdata_d[iss_pkg::OVERFLOW_BIT] = second_overflow_flag_q;
			iss_pkg::IRQ_STATUS_ADDR:
				rdata_d[1:0] = irq_status_q;
			iss_pkg::IRQ_MASK_ADDR:
				rdata_d[1:0] = irq_mask_q;
			default:
				rdata_d = iss_pkg::UNMAPPED_DATA;
		endcase
	end

	// One wait state; unmapped addresses still ack, so a stray access never hangs the bus
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_q <= 1'b0;
		else
			ack_q <= access;
	end

	// Data is zero outside an answered read, so a stale value never leaks
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata_q <= '0;
		else
			rdata_q <= rd_en ? rdata_d : iss_pkg::UNMAPPED_DATA;
	end

	assign wb_rsp_o.ack = ack_q;
	assign wb_rsp_o.dat = rdata_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Reset leaves every register clear before the first request
	reset_zero_a: assert property (
		$fell(rst_i) |-> pending_q == '0 && !second_overflow_flag_q && !ack_q
		&& irq_status_q == '0 && irq_mask_q == '0 && wb_rsp_o.dat == '0)
		else $error("registers not cleared by reset");

	// Channel flags are captured one clock after they change
	low_map_a: assert property ($past(channel_pending_flag_i[8:1]) == pending_q[8:1])
		else $error("low summary does not follow channels 8..1");

	high_map_a: assert property ($past(channel_pending_flag_i[16:9]) == pending_q[16:9])
		else $error("high summary does not follow channels 16..9");

	zero_map_a: assert property ($past(channel_pending_flag_i[0]) == pending_q[0])
		else $error("zero summary does not follow channel 0");

	pending_set_a: assert property (channel_pending_flag_i[0] |=> pending_q[0])
		else $error("channel 0 summary not set");

	pending_clear_a: assert property (channel_pending_flag_i == '0 |=> pending_q == '0)
		else $error("summary bit not cleared");

	or_latency_a: assert property (
		$changed(channel_pending_flag_i) |=> pending_q == $past(channel_pending_flag_i))
		else $error("summary lagged more than one clock");

	// Reads return the registers as they stood at the request edge
	low_read_a: assert property (
		rd_en && reg_hit(wb_req_i.adr, iss_pkg::SUMMARY_LOW_ADDR)
		|=> wb_rsp_o.dat[7:0] == $past(pending_q[8:1]))
		else $error("low summary read wrong");

	high_read_a: assert property (
		rd_en && reg_hit(wb_req_i.adr, iss_pkg::SUMMARY_HIGH_ADDR)
		|=> wb_rsp_o.dat[7:0] == $past(pending_q[16:9]))
		else $error("high summary read wrong");

	zero_read_a: assert property (
		rd_en && reg_hit(wb_req_i.adr, iss_pkg::SUMMARY_ZERO_ADDR)
		|=> wb_rsp_o.dat[6:0] == 7'h00 && wb_rsp_o.dat[7] == $past(pending_q[0]))
		else $error("zero summary read wrong");

	timer_read_a: assert property (
		rd_en && reg_hit(wb_req_i.adr, iss_pkg::TIMER_STATUS_ADDR)
		|=> wb_rsp_o.dat[iss_pkg::OVERFLOW_BIT] == $past(second_overflow_flag_q))
		else $error("overflow flag read wrong");

	timer_reserved_a: assert property (
		rd_en && reg_hit(wb_req_i.adr, iss_pkg::TIMER_STATUS_ADDR)
		|=> wb_rsp_o.dat[7:1] == 7'h00)
		else $error("timer status reserved bits not zero");

	status_data_a: assert property (
		status_read
		|=> wb_rsp_o.dat[1:0] == $past(irq_status_q))
		else $error("interrupt status read wrong");

	mask_read_a: assert property (
		rd_en && reg_hit(wb_req_i.adr, iss_pkg::IRQ_MASK_ADDR)
		|=> wb_rsp_o.dat[1:0] == $past(irq_mask_q))
		else $error("interrupt mask read wrong");

	unmapped_read_a: assert property (
		rd_en && !addr_mapped(wb_req_i.adr)
		|=> wb_rsp_o.dat == iss_pkg::UNMAPPED_DATA)
		else $error("unmapped read not zero");

	reserved_bits_a: assert property (
		ack_q |-> wb_rsp_o.dat[31:8] == 24'h00_0000)
		else $error("upper data bits not zero");

	// Timer overflow flag
	tick_sets_a: assert property (second_tick_i |=> second_overflow_flag_q)
		else $error("overflow flag not set");

	tick_wins_a: assert property (second_tick_i && overflow_clear |=> second_overflow_flag_q)
		else $error("clear beat a same-cycle expiry");

	w1c_clear_a: assert property (
		overflow_clear && !second_tick_i |=> !second_overflow_flag_q)
		else $error("overflow flag not cleared by write one");

	write_zero_keeps_a: assert property (
		wr_en && !wb_req_i.dat[iss_pkg::OVERFLOW_BIT] && !second_tick_i
		|=> second_overflow_flag_q == $past(second_overflow_flag_q))
		else $error("write of zero changed the overflow flag");

	flag_holds_a: assert property (
		!second_tick_i && !wr_en |=> second_overflow_flag_q == $past(second_overflow_flag_q))
		else $error("overflow flag changed without cause");

	// Sticky status, mask and the level interrupt
	status_sticky_a: assert property (
		!status_read |=> (irq_status_q & $past(irq_status_q)) == $past(irq_status_q))
		else $error("status bit lost without a read");

	read_clears_a: assert property (
		status_read && events == '0 |=> irq_status_q == '0)
		else $error("status not cleared by read");

	event_kept_a: assert property (
		status_read && second_tick_i |=> irq_status_q[iss_pkg::EV_OVERFLOW_BIT])
		else $error("event in read cycle lost");

	event_sets_a: assert property (second_tick_i |=> irq_status_q[iss_pkg::EV_OVERFLOW_BIT])
		else $error("timer event not recorded");

	channel_event_a: assert property (
		(|pending_q) && !any_pending_q |=> irq_status_q[iss_pkg::EV_CHANNEL_BIT])
		else $error("channel event not recorded");

	any_pending_track_a: assert property (any_pending_q == $past(|pending_q))
		else $error("pending history wrong");

	mask_write_a: assert property (
		mask_write |=> irq_mask_q == $past(wb_req_i.dat[1:0]))
		else $error("mask write lost");

	mask_hold_a: assert property (
		!mask_write |=> irq_mask_q == $past(irq_mask_q))
		else $error("mask changed without a write");

	irq_raise_a: assert property (
		second_tick_i && irq_mask_q[iss_pkg::EV_OVERFLOW_BIT] && !mask_write |=> irq_o)
		else $error("unmasked event did not raise the interrupt");

	irq_hold_a: assert property (
		irq_o && !status_read && !mask_write |=> irq_o)
		else $error("interrupt dropped without a read");

	irq_drop_a: assert property (irq_mask_q == '0 |-> !irq_o)
		else $error("masked interrupt asserted");

	// Bus answer
	ack_follows_a: assert property (access |=> ack_q)
		else $error("request not answered");

	ack_cause_a: assert property (!access |=> !ack_q)
		else $error("ack without a request");

	ack_pulse_a: assert property (ack_q |=> !ack_q)
		else $error("ack held longer than one cycle");

	dat_idle_a: assert property (!ack_q |-> wb_rsp_o.dat == iss_pkg::UNMAPPED_DATA)
		else $error("read data outside ack");

	wr_no_read_a: assert property (
		ack_q && wb_req_i.we |-> wb_rsp_o.dat == iss_pkg::UNMAPPED_DATA)
		else $error("write answered with data");

	tick_cover_c: cover property (second_tick_i ##1 second_overflow_flag_q);
	clear_cover_c: cover property (overflow_clear);
	clash_cover_c: cover property (second_tick_i && overflow_clear);
	irq_cover_c: cover property (irq_o);
	ch0_cover_c: cover property (pending_q[0]);
endmodule : iss_summary
`default_nettype wire

// ==== shared/iss_pkg.sv ====
`default_nettype none
package iss_pkg;
	localparam int unsigned NUM_CHANNELS = 17;
	localparam int unsigned ADDR_W       = 12;
	localparam int unsigned REG_W        = 8;
	// Printed offsets are multiples of four, so they are byte addresses
	localparam logic [11:0] SUMMARY_LOW_ADDR  = 12'h2c0;
	localparam logic [11:0] SUMMARY_HIGH_ADDR = 12'h300;
	localparam logic [11:0] SUMMARY_ZERO_ADDR = 12'h380;
	localparam logic [11:0] TIMER_STATUS_ADDR = 12'h3c0;
	localparam logic [11:0] IRQ_STATUS_ADDR   = 12'h3d0;
	localparam logic [11:0] IRQ_MASK_ADDR     = 12'h3d4;
	localparam logic [7:0]  RESET_VALUE       = 8'h00;
	localparam int unsigned OVERFLOW_BIT      = 0;
	localparam int unsigned ZERO_CH_BIT       = 7;
	localparam int unsigned LOW_CH_BASE       = 1;
	localparam int unsigned HIGH_CH_BASE      = 9;
	// Interrupt status layout
	localparam int unsigned EV_CHANNEL_BIT    = 0;
	localparam int unsigned EV_OVERFLOW_BIT   = 1;
	localparam logic [31:0] UNMAPPED_DATA     = 32'h0000_0000;

	typedef struct packed {
		logic [11:0] adr;
		logic [31:0] dat;
		logic [3:0]  sel;
		logic        we;
		logic        cyc;
		logic        stb;
	} iss_wb_req_s;

	typedef struct packed {
		logic [31:0] dat;
		logic        ack;
	} iss_wb_rsp_s;
endpackage : iss_pkg
`default_nettype wire
